// file: core/srw_debounce.sv
// Level debouncer for the manual pushbutton input
module srw_debounce
  import srw_pkg::*;
#(
  parameter int STABLE_CYCLES = SRW_DEB_CYCLES
) (
  input wire logic i_core_clk,
  input wire logic i_resetn,
  input wire logic i_level,
  output logic o_level
);

  localparam int CW = $clog2(STABLE_CYCLES + 1);
  localparam logic [CW-1:0] LAST = CW'(STABLE_CYCLES - 1);

  typedef struct packed {
    logic level;
    logic [CW-1:0] cnt;
  } srw_deb_state_t;

  srw_deb_state_t s;
  srw_deb_state_t next_s;

  // ----------------------------------------------------------------
  // New level taken only after it held steady
  // ----------------------------------------------------------------
  always_comb begin
    next_s = s;
    if (i_level == s.level) begin
      next_s.cnt = '0;
    end else if (s.cnt == LAST) begin
      next_s.level = i_level;
      next_s.cnt = '0;
    end else begin
      next_s.cnt = s.cnt + CW'(1);
    end
  end

  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      s.level <= 1'b1;
      s.cnt <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign o_level = s.level;

endmodule

// file: core/srw_pkg.sv
// Shared constants and types for the supervisor reset and watchdog block
package srw_pkg;

  // ----------------------------------------------------------------
  // Timebase
  // ----------------------------------------------------------------
  localparam int SRW_CLK_NS = 40;
  localparam int SRW_TICK_NS = 1000;
  localparam int SRW_TICK_CYCLES = SRW_TICK_NS / SRW_CLK_NS;

  // ----------------------------------------------------------------
  // Timeouts, counted in timebase ticks
  // ----------------------------------------------------------------
  localparam int SRW_STRETCH_MS = 200;
  localparam int SRW_STRETCH_TICKS = SRW_STRETCH_MS * 1000000 / SRW_TICK_NS;
  localparam int SRW_WDOG_MS = 1600;
  localparam int SRW_WDOG_TICKS = SRW_WDOG_MS * 1000000 / SRW_TICK_NS;

  // ----------------------------------------------------------------
  // Pushbutton debounce, least time rounded up to cycles
  // ----------------------------------------------------------------
  localparam int SRW_DEB_NS = 300;
  localparam int SRW_DEB_CYCLES = (SRW_DEB_NS + SRW_CLK_NS - 1) / SRW_CLK_NS;

  // ----------------------------------------------------------------
  // Product variants and reset sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    SRW_WDOG_LOW,
    SRW_WDOG_HIGH,
    SRW_NO_WDOG
  } srw_variant_t;

  typedef enum logic [1:0] {
    SRW_RST_HOLD,
    SRW_RST_STRETCH,
    SRW_RST_RUN
  } srw_rst_state_t;

endpackage

// file: core/srw_supervisor.sv
// Supervisor: reset sequencer, watchdog and power-fail warning
module srw_supervisor
  import srw_pkg::*;
#(
  parameter srw_variant_t VARIANT = SRW_WDOG_LOW,
  parameter int TICK_CYCLES = SRW_TICK_CYCLES,
  parameter int STRETCH_TICKS = SRW_STRETCH_TICKS,
  parameter int WDOG_TICKS = SRW_WDOG_TICKS,
  parameter int DEB_CYCLES = SRW_DEB_CYCLES
) (
  input wire logic i_core_clk,
  input wire logic i_resetn,
  input wire logic i_supply_low,
  input wire logic i_pushbutton_in_n,
  input wire logic i_pushbutton_driven,
  input wire logic i_activity_strobe_in,
  input wire logic i_activity_strobe_driven,
  input wire logic i_powerfail_sense_above,
  output logic o_reset_n,
  output logic o_reset,
  output logic o_timeout_flag_n,
  output logic o_powerfail_warn_n
);

  localparam int TW = $clog2(TICK_CYCLES + 1);
  localparam int SW = $clog2(STRETCH_TICKS + 1);
  localparam int WW = $clog2(WDOG_TICKS + 1);
  localparam logic [TW-1:0] TICK_LAST = TW'(TICK_CYCLES - 1);
  localparam logic [SW-1:0] STRETCH_LAST = SW'(STRETCH_TICKS - 1);
  localparam logic [WW-1:0] WDOG_LAST = WW'(WDOG_TICKS - 1);
  localparam bit HAS_WDOG = (VARIANT != SRW_NO_WDOG);
  localparam bit HAS_LOW = (VARIANT != SRW_WDOG_HIGH);
  localparam bit HAS_HIGH = (VARIANT != SRW_WDOG_LOW);
  localparam int SYNC_W = 2;

  typedef struct packed {
    logic [SYNC_W-1:0] sup_sync;
    logic [SYNC_W-1:0] pb_sync;
    logic [SYNC_W-1:0] pbd_sync;
    logic [SYNC_W-1:0] act_sync;
    logic [SYNC_W-1:0] actd_sync;
    logic [SYNC_W-1:0] pf_sync;
    logic act_prev;
    logic [TW-1:0] tick_cnt;
    logic tick;
    srw_rst_state_t rst_state;
    logic [SW-1:0] stretch_cnt;
    logic [WW-1:0] wd_cnt;
    logic wd_expired;
    logic reset_n;
    logic reset_hi;
    logic timeout_n;
    logic warn_n;
  } srw_state_t;

  srw_state_t s;
  srw_state_t next_s;

  logic pb_level;
  logic pb_clean;
  logic pb_req;
  logic supply_low;
  logic cause;
  logic wd_enabled;
  logic act_edge;

  // ----------------------------------------------------------------
  // Pushbutton conditioning
  // ----------------------------------------------------------------
  // Undriven pin behaves as if pulled high
  assign pb_level = s.pbd_sync[1] ? s.pb_sync[1] : 1'b1;

  srw_debounce #(
    .STABLE_CYCLES(DEB_CYCLES)
  ) u_pb_debounce (
    .i_core_clk(i_core_clk),
    .i_resetn(i_resetn),
    .i_level(pb_level),
    .o_level(pb_clean)
  );

  assign pb_req = !pb_clean;
  assign supply_low = s.sup_sync[1];
  assign cause = supply_low || pb_req;
  assign wd_enabled = HAS_WDOG && s.actd_sync[1];
  assign act_edge = s.act_sync[1] ^ s.act_prev;

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    next_s = s;

    // Pin synchronisers
    next_s.sup_sync = {s.sup_sync[0], i_supply_low};
    next_s.pb_sync = {s.pb_sync[0], i_pushbutton_in_n};
    next_s.pbd_sync = {s.pbd_sync[0], i_pushbutton_driven};
    next_s.act_sync = {s.act_sync[0], i_activity_strobe_in};
    next_s.actd_sync = {s.actd_sync[0], i_activity_strobe_driven};
    next_s.pf_sync = {s.pf_sync[0], i_powerfail_sense_above};
    next_s.act_prev = s.act_sync[1];

    // Free-running timebase
    next_s.tick = 1'b0;
    if (s.tick_cnt == TICK_LAST) begin
      next_s.tick_cnt = '0;
      next_s.tick = 1'b1;
    end else begin
      next_s.tick_cnt = s.tick_cnt + TW'(1);
    end

    // Reset sequencer
    unique case (s.rst_state)
      SRW_RST_HOLD: begin
        next_s.stretch_cnt = '0;
        if (!cause) begin
          next_s.rst_state = SRW_RST_STRETCH;
        end
      end
      SRW_RST_STRETCH: begin
        if (cause) begin
          next_s.rst_state = SRW_RST_HOLD;
          next_s.stretch_cnt = '0;
        end else if (s.tick) begin
          if (s.stretch_cnt == STRETCH_LAST) begin
            next_s.rst_state = SRW_RST_RUN;
            next_s.stretch_cnt = '0;
          end else begin
            next_s.stretch_cnt = s.stretch_cnt + SW'(1);
          end
        end
      end
      SRW_RST_RUN: begin
        // Watchdog state plays no part here
        if (cause) begin
          next_s.rst_state = SRW_RST_HOLD;
        end
      end
      default: begin
        next_s.rst_state = SRW_RST_HOLD;
      end
    endcase

    next_s.reset_n = HAS_LOW ? (next_s.rst_state == SRW_RST_RUN) : 1'b1;
    next_s.reset_hi = HAS_HIGH ? (next_s.rst_state != SRW_RST_RUN) : 1'b0;

    // Watchdog
    if (!wd_enabled) begin
      next_s.wd_cnt = '0;
      next_s.wd_expired = 1'b0;
    end else if (act_edge) begin
      next_s.wd_cnt = '0;
      next_s.wd_expired = 1'b0;
    end else if (s.tick && !s.wd_expired) begin
      if (s.wd_cnt == WDOG_LAST) begin
        next_s.wd_expired = 1'b1;
      end else begin
        next_s.wd_cnt = s.wd_cnt + WW'(1);
      end
    end
    next_s.timeout_n = HAS_WDOG ? !(supply_low || next_s.wd_expired) : 1'b1;

    // Power-fail warning, own path only
    next_s.warn_n = s.pf_sync[1];
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      s.sup_sync <= '1;
      s.pb_sync <= '1;
      s.pbd_sync <= '0;
      s.act_sync <= '0;
      s.actd_sync <= '0;
      s.pf_sync <= '1;
      s.act_prev <= 1'b0;
      s.tick_cnt <= '0;
      s.tick <= 1'b0;
      s.rst_state <= SRW_RST_HOLD;
      s.stretch_cnt <= '0;
      s.wd_cnt <= '0;
      s.wd_expired <= 1'b0;
      s.reset_n <= !HAS_LOW;
      s.reset_hi <= HAS_HIGH;
      s.timeout_n <= !HAS_WDOG;
      s.warn_n <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  assign o_reset_n = s.reset_n;
  assign o_reset = s.reset_hi;
  assign o_timeout_flag_n = s.timeout_n;
  assign o_powerfail_warn_n = s.warn_n;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (!i_resetn);

  AST_PB_ASSERTS: assert property (
    pb_req |=> (s.rst_state == SRW_RST_HOLD) && (o_reset_n == !HAS_LOW)
  ) else $error("pushbutton did not hold reset");

  AST_PB_FLOAT: assert property (
    !s.pbd_sync[1] [*8] |=> !pb_req
  ) else $error("floating pushbutton requested reset");

  AST_PB_DEBOUNCE: assert property (
    !pb_req && $fell(pb_level) ##1 $rose(pb_level)
      |-> !pb_req
  ) else $error("one-cycle glitch passed debounce");

  AST_SUPPLY_HOLDS: assert property (
    supply_low |=> s.rst_state == SRW_RST_HOLD && o_reset == HAS_HIGH
  ) else $error("supply low did not hold reset");

  AST_STRETCH_START: assert property (
    s.rst_state == SRW_RST_HOLD && !cause
      |=> s.rst_state == SRW_RST_STRETCH && s.stretch_cnt == '0
  ) else $error("stretch did not start from zero");

  AST_STRETCH_END: assert property (
    s.rst_state == SRW_RST_STRETCH && s.tick && !cause && s.stretch_cnt == STRETCH_LAST
      |=> s.rst_state == SRW_RST_RUN ##0 (o_reset_n || !HAS_LOW)
  ) else $error("reset not released at end of stretch");

  AST_NO_EARLY_RELEASE: assert property (
    s.rst_state == SRW_RST_STRETCH && s.stretch_cnt != STRETCH_LAST
      |=> s.rst_state != SRW_RST_RUN
  ) else $error("reset released before stretch ended");

  AST_COMPLEMENT: assert property (
    HAS_LOW && HAS_HIGH |-> o_reset == !o_reset_n
  ) else $error("reset outputs not complementary");

  AST_WD_RESTART: assert property (
    wd_enabled && act_edge |=> s.wd_cnt == '0 && !s.wd_expired
  ) else $error("strobe edge did not restart watchdog");

  AST_WD_EXPIRE: assert property (
    wd_enabled && !act_edge && s.tick && s.wd_cnt == WDOG_LAST && !s.wd_expired
      |=> s.wd_expired ##0 !o_timeout_flag_n
  ) else $error("watchdog did not expire on time");

  AST_WD_FLOAT: assert property (
    !s.actd_sync[1] |=> !s.wd_expired
  ) else $error("timeout raised while strobe floats");

  AST_SUPPLY_FLAG: assert property (
    supply_low && HAS_WDOG |=> !o_timeout_flag_n
  ) else $error("flag not low during supply low");

  AST_WD_NO_RESET: assert property (
    s.rst_state == SRW_RST_RUN && !cause && s.wd_expired |=> s.rst_state == SRW_RST_RUN
  ) else $error("watchdog asserted reset");

  AST_PF_FOLLOW: assert property (
    ##1 o_powerfail_warn_n == $past(s.pf_sync[1])
  ) else $error("warning does not follow sense input");

  AST_PF_ALONE: assert property (
    $past(s.pf_sync[1]) == $past(s.pf_sync[1], 2) && !$stable(o_reset_n)
      |-> $stable(o_powerfail_warn_n)
  ) else $error("warning moved with reset");

  AST_HIGH_ONLY: assert property (
    VARIANT == SRW_WDOG_HIGH |-> o_reset_n
  ) else $error("active-low reset used on high-only variant");

  AST_FLAG_RELEASE: assert property (
    s.wd_expired && act_edge && wd_enabled && !supply_low ##1 !supply_low
      |-> o_timeout_flag_n
  ) else $error("flag not released by strobe edge");

  AST_TICK_PERIOD: assert property (
    s.tick |=> !s.tick
  ) else $error("timebase tick longer than one cycle");

endmodule

// file: test/srw_proc_model.sv
// Processor model: takes the supervisor reset and toggles the activity strobe
module srw_proc_model (
  input wire logic i_core_clk,
  input wire logic i_resetn,
  input wire logic i_reset_n,
  input wire logic i_run,
  input wire logic i_float,
  output logic o_strobe,
  output logic o_strobe_driven
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] cnt;
  logic lvl;
  logic noise;
  // Toggle only while out of reset, every 4 cycles
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      cnt <= 2'h0;
      lvl <= 1'b0;
      noise <= 1'b0;
    end else begin
      noise <= ~noise;
      if (i_run && i_reset_n && !i_float) begin
        cnt <= cnt + 2'h1;
        if (cnt == 2'h3) begin
          lvl <= ~lvl;
        end
      end
    end
  end
  // Released pin shows a changing level, not the last one
  assign o_strobe = i_float ? noise : lvl;
  assign o_strobe_driven = ~i_float;
endmodule

// file: test/tb_top.sv
// Testbench for the supervisor reset and watchdog block
module tb_top;
  import srw_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic sup = 1'b1;
  logic pb = 1'b1;
  logic pbd = 1'b1;
  logic run = 1'b0;
  logic flt = 1'b0;
  logic pf = 1'b1;
  logic st, std, rn, r, fn, wn, rn2, r2, fn2, rn3, r3, fn3;
  int mismatches = 0;
  int samples_checked = 0;
  localparam int TB_TICK = 2;
  localparam int TB_STRETCH = 5;
  localparam int TB_WDOG = 8;
  always #20 clk = ~clk;

  srw_supervisor #(.VARIANT(SRW_WDOG_LOW), .TICK_CYCLES(TB_TICK), .STRETCH_TICKS(TB_STRETCH),
    .WDOG_TICKS(TB_WDOG)) i_dut (.i_core_clk(clk), .i_resetn(rstn),
    .i_supply_low(sup), .i_pushbutton_in_n(pb), .i_pushbutton_driven(pbd),
    .i_activity_strobe_in(st), .i_activity_strobe_driven(std),
    .i_powerfail_sense_above(pf), .o_reset_n(rn), .o_reset(r),
    .o_timeout_flag_n(fn), .o_powerfail_warn_n(wn));
  srw_supervisor #(.VARIANT(SRW_NO_WDOG), .TICK_CYCLES(TB_TICK), .STRETCH_TICKS(TB_STRETCH),
    .WDOG_TICKS(TB_WDOG)) i_dut_nw (.i_core_clk(clk), .i_resetn(rstn),
    .i_supply_low(sup), .i_pushbutton_in_n(pb), .i_pushbutton_driven(pbd),
    .i_activity_strobe_in(st), .i_activity_strobe_driven(std),
    .i_powerfail_sense_above(pf), .o_reset_n(rn2), .o_reset(r2),
    .o_timeout_flag_n(fn2), .o_powerfail_warn_n());
  srw_supervisor #(.VARIANT(SRW_WDOG_HIGH), .TICK_CYCLES(TB_TICK), .STRETCH_TICKS(TB_STRETCH),
    .WDOG_TICKS(TB_WDOG)) i_dut_hi (.i_core_clk(clk), .i_resetn(rstn),
    .i_supply_low(sup), .i_pushbutton_in_n(pb), .i_pushbutton_driven(pbd),
    .i_activity_strobe_in(st), .i_activity_strobe_driven(std),
    .i_powerfail_sense_above(pf), .o_reset_n(rn3), .o_reset(r3),
    .o_timeout_flag_n(fn3), .o_powerfail_warn_n());
  srw_proc_model i_cpu (.i_core_clk(clk), .i_resetn(rstn), .i_reset_n(rn), .i_run(run),
    .i_float(flt), .o_strobe(st), .o_strobe_driven(std));

  function automatic logic pick(input int s);
    case (s)
      0: return rn;
      1: return fn;
      default: return wn;
    endcase
  endfunction

  task automatic cmp(input logic e, input logic g);
    samples_checked++;
    if (g !== e) begin
      mismatches++;
      $display("Error at %0t: expected %0h got %0h", $time, e, g);
    end
  endtask

  task automatic hold(input int s, input logic v, input int n);
    repeat (n) begin
      @(negedge clk);
      cmp(v, pick(s));
    end
  endtask

  task automatic wait_val(input int s, input logic v, input int lo, input int hi);
    int n;
    n = 0;
    while (pick(s) !== v && n <= hi) begin
      @(negedge clk);
      n++;
    end
    samples_checked++;
    if (n < lo || n > hi) begin
      mismatches++;
      $display("Error at %0t: waited %0h cycles, bounds %0h to %0h", $time, n, lo, hi);
    end
  endtask

  // ----------------------------------------------------------------
  // Variant outputs
  // ----------------------------------------------------------------
  always @(negedge clk) begin
    if (rstn) begin
      cmp(~rn2, r2);
      cmp(rn, rn2);
      cmp(1'b1, fn2);
      cmp(1'b0, r);
      cmp(1'b1, rn3);
      cmp(~rn, r3);
      cmp(fn, fn3);
    end
  end

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_powerup;
    hold(0, 1'b0, 20);
    cmp(1'b0, fn);
    sup = 1'b0;
    wait_val(0, 1'b1, 9, 20);
  endtask

  task automatic t_pushbutton;
    pb = 1'b0;
    @(negedge clk);
    pb = 1'b1;
    @(negedge clk);
    pb = 1'b0;
    repeat (4) @(negedge clk);
    pb = 1'b1;
    hold(0, 1'b1, 20);
    pbd = 1'b0;
    pb = 1'b0;
    hold(0, 1'b1, 30);
    pbd = 1'b1;
    wait_val(0, 1'b0, 9, 14);
    repeat (10) @(negedge clk);
    pb = 1'b1;
    hold(0, 1'b0, 16);
    wait_val(0, 1'b1, 1, 20);
  endtask

  task automatic t_watchdog;
    run = 1'b1;
    wait_val(1, 1'b1, 0, 12);
    hold(1, 1'b1, 60);
    run = 1'b0;
    wait_val(1, 1'b0, 10, 28);
    hold(0, 1'b1, 10);
    run = 1'b1;
    wait_val(1, 1'b1, 0, 10);
    flt = 1'b1;
    hold(1, 1'b1, 60);
    flt = 1'b0;
  endtask

  task automatic t_supply;
    sup = 1'b1;
    wait_val(1, 1'b0, 0, 6);
    cmp(1'b0, rn);
    pf = 1'b0;
    wait_val(2, 1'b0, 0, 5);
    pf = 1'b1;
    wait_val(2, 1'b1, 0, 5);
    hold(1, 1'b0, 20);
    sup = 1'b0;
    wait_val(0, 1'b1, 9, 20);
    wait_val(1, 1'b1, 0, 12);
  endtask

  task automatic t_midreset;
    rstn = 1'b0;
    @(negedge clk);
    cmp(1'b0, rn);
    cmp(1'b0, fn);
    cmp(1'b1, wn);
    @(negedge clk);
    rstn = 1'b1;
    hold(0, 1'b0, 8);
    wait_val(0, 1'b1, 1, 12);
  endtask

  task automatic conclude;
    $display("Counts: %0d mismatches, %0d samples checked", mismatches, samples_checked);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  initial begin
    repeat (2) @(negedge clk);
    rstn = 1'b1;
    t_powerup();
    t_pushbutton();
    t_watchdog();
    t_supply();
    t_midreset();
    conclude();
  end
endmodule
